// ---- src/raw_params.svh ----
// constants for the alarm, watchdog and square-wave block
`ifndef RAW_PARAMS_SVH
`define RAW_PARAMS_SVH

`define RAW_ADDR_CTRL 8'h08
`define RAW_ADDR_WDOG 8'h09
`define RAW_ADDR_ALARM_MONTH_AND_ENABLES 8'h0a
`define RAW_ADDR_AL_DATE 8'h0b
`define RAW_ADDR_AL_HOUR 8'h0c
`define RAW_ADDR_AL_MIN 8'h0d
`define RAW_ADDR_AL_SEC 8'h0e
`define RAW_ADDR_FLAGS 8'h0f
`define RAW_ADDR_SQW 8'h13

`define RAW_CTRL_OUT_BIT 7
`define RAW_CTRL_FT_BIT 6
`define RAW_WD_ROUTE_BIT 7
`define RAW_WD_MULT_MSB 6
`define RAW_WD_MULT_LSB 2
`define RAW_WD_RES_MSB 1
`define RAW_WD_RES_LSB 0
`define RAW_AL_PIN_EN_BIT 7
`define RAW_SQW_EN_BIT 6
`define RAW_BK_AL_EN_BIT 5
`define RAW_HT_BIT 6
`define RAW_RPT_BIT 7
`define RAW_RPT5_BIT 6
`define RAW_FLAG_WD_BIT 7
`define RAW_FLAG_AL_BIT 6
`define RAW_FLAG_BL_BIT 4
`define RAW_SQW_RATE_MSB 7
`define RAW_SQW_RATE_LSB 4

`define RAW_CTRL_RST 8'h80
`define RAW_AL_HOUR_RST 8'h40
`define RAW_ZERO_BYTE 8'h00

`define RAW_MASK_MONTH 8'h1f
`define RAW_MASK_DATE 8'h3f
`define RAW_MASK_HOUR 8'h3f
`define RAW_MASK_MIN 8'h7f
`define RAW_MASK_SEC 8'h7f

`define RAW_RPT_SECOND 5'h1f
`define RAW_RPT_MINUTE 5'h1e
`define RAW_RPT_HOUR 5'h1c
`define RAW_RPT_DAY 5'h18
`define RAW_RPT_MONTH 5'h10
`define RAW_RPT_YEAR 5'h00

`define RAW_PRESCALE_W 17
`define RAW_RES_MASK_16TH 17'h007ff
`define RAW_RES_MASK_QUARTER 17'h01fff
`define RAW_RES_MASK_SECOND 17'h07fff
`define RAW_RES_MASK_4SEC 17'h1ffff
`define RAW_FT_TAP 5
`define RAW_SQW_OSC_CODE 4'h1
`define RAW_SQW_OFF_CODE 4'h0

`define RAW_CLK_MHZ 250
`define RAW_RESET_RECOVERY_TIME_NORM_US 97000
`define RAW_RESET_RECOVERY_TIME_HALT_US 100000
`define RAW_RESET_RECOVERY_TIME_FAST_US 1000

`endif

// ---- src/raw_pkg.sv ----
// types shared by the alarm, watchdog and square-wave block
package raw_pkg;

  typedef struct packed {
    logic [7:0] month;
    logic [7:0] date;
    logic [7:0] hour;
    logic [7:0] minute;
    logic [7:0] second;
  } raw_time_t;

  typedef struct packed {
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } raw_reg_req_t;

  typedef enum logic [2:0] {
    RAW_SCOPE_SECOND,
    RAW_SCOPE_MINUTE,
    RAW_SCOPE_HOUR,
    RAW_SCOPE_DAY,
    RAW_SCOPE_MONTH,
    RAW_SCOPE_YEAR
  } raw_scope_t;

  typedef enum logic [1:0] {
    RAW_RST_RUN,
    RAW_RST_FAIL,
    RAW_RST_RECOVER
  } raw_rst_state_t;

endpackage

// ---- src/raw_alarm_wdog.sv ----
// alarm, watchdog, square-wave and power-on-reset logic of the clock
`include "raw_params.svh"

// Function
// [RULE1] alarm settings live at 0x0a to 0x0e
// [RULE2] repeat code picks compared alarm fields
// [RULE3] undefined repeat codes act as every second
// [RULE4] match sets flag, pin if enabled
// [RULE5] pointer on flags holds alarm interrupt off
// [RULE6] host disables alarm with zero date, code
// [RULE7] flags read releases pin, clears flag after
// [RULE8] back-up alarm drives pin only if both enabled
// [RULE9] power-up clears both alarm enables
// [RULE10] watchdog register: multiplier above resolution code
// [RULE11] timeout equals multiplier times resolution
// [RULE12] timeout may vary one resolution step
// [RULE13] expiry sets flag bit7, flags read clears
// [RULE14] route bit picks interrupt or reset pulse
// [RULE15] reset-routed expiry clears watchdog and enables
// [RULE16] kick edge or register write restarts count
// [RULE17] writing 0x00 releases pin, disables watchdog
// [RULE18] power-up clears watchdog register
// [RULE19] routed watchdog overrides frequency test output
// [RULE20] rate code selects square wave frequency
// [RULE21] square wave only while its enable set
// [RULE22] fixed 32k runs unless halted or back-up
// [RULE23] reset low on power fail, then recovery
// [RULE24] recovery length from select and halt bits
// [RULE25] flags layout: bits 7, 6, 4
// [RULE26] power-up defaults for control bits
// [RULE27] match once per seconds update, scoped fields
module raw_alarm_wdog
  import raw_pkg::*;
#(
  parameter int RESET_RECOVERY_TIME_NORM_CYC = `RAW_RESET_RECOVERY_TIME_NORM_US * `RAW_CLK_MHZ,
  parameter int RESET_RECOVERY_TIME_HALT_CYC = `RAW_RESET_RECOVERY_TIME_HALT_US * `RAW_CLK_MHZ,
  parameter int RESET_RECOVERY_TIME_FAST_CYC = `RAW_RESET_RECOVERY_TIME_FAST_US * `RAW_CLK_MHZ
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // register access from the serial front end
  input raw_reg_req_t regReq,
  input wire logic [7:0] addrPtr,
  output logic [7:0] regRdata,
  // time counters and monitors, same clock
  input wire logic secTick,
  input raw_time_t timeNow,
  input wire logic oscillatorHalt,
  input wire logic recoveryLengthSelect,
  input wire logic batteryLowFlag,
  // asynchronous pins
  input wire logic oscPin,
  input wire logic supplyOk,
  input wire logic watchdogKickInput,
  // open-drain and push-pull outputs
  output logic sharedIrqOut,
  output logic sharedIrqOe,
  output logic resetOut,
  output logic resetOe,
  output logic squareWavePin,
  output logic fixed32khzOutput
);

  if (RESET_RECOVERY_TIME_NORM_CYC < 1 || RESET_RECOVERY_TIME_HALT_CYC < 1 || RESET_RECOVERY_TIME_FAST_CYC < 1) begin : g_check
    $error("recovery counts must be at least one cycle");
  end

  function automatic logic fieldEq(input logic [7:0] a, input logic [7:0] b, input logic [7:0] mask);
    return ((a ^ b) & mask) == `RAW_ZERO_BYTE;
  endfunction

  function automatic raw_scope_t scopeOf(input logic [4:0] rpt);
    raw_scope_t s;
    s = RAW_SCOPE_SECOND;
    case (rpt)
      `RAW_RPT_MINUTE: s = RAW_SCOPE_MINUTE;
      `RAW_RPT_HOUR: s = RAW_SCOPE_HOUR;
      `RAW_RPT_DAY: s = RAW_SCOPE_DAY;
      `RAW_RPT_MONTH: s = RAW_SCOPE_MONTH;
      `RAW_RPT_YEAR: s = RAW_SCOPE_YEAR;
      default: s = RAW_SCOPE_SECOND; // RULE3
    endcase
    return s;
  endfunction

  function automatic logic [`RAW_PRESCALE_W-1:0] resMask(input logic [1:0] res);
    logic [`RAW_PRESCALE_W-1:0] m;
    m = `RAW_RES_MASK_4SEC;
    case (res)
      2'h0: m = `RAW_RES_MASK_16TH;
      2'h1: m = `RAW_RES_MASK_QUARTER;
      2'h2: m = `RAW_RES_MASK_SECOND;
      default: m = `RAW_RES_MASK_4SEC;
    endcase
    return m;
  endfunction

  // synchronisers for the pins
  logic oscMeta, oscSync, oscPrev;
  logic supplyMeta, supplySync, supplyPrev;
  logic kickMeta, kickSync, kickPrev;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      {oscMeta, oscSync, oscPrev} <= 3'h0;
      {supplyMeta, supplySync, supplyPrev} <= 3'h0;
      {kickMeta, kickSync, kickPrev} <= 3'h0;
    end else begin
      {oscMeta, oscSync, oscPrev} <= {oscPin, oscMeta, oscSync};
      {supplyMeta, supplySync, supplyPrev} <= {supplyOk, supplyMeta, supplySync};
      {kickMeta, kickSync, kickPrev} <= {watchdogKickInput, kickMeta, kickSync};
    end
  end

  wire oscRise = oscSync & ~oscPrev;
  wire powerUp = supplySync & ~supplyPrev;
  wire backup = ~supplySync;
  wire kickEdge = kickSync ^ kickPrev;

  // registers
  logic [7:0] ctrlReg;
  logic [7:0] wdReg;
  logic [7:0] alarmReg [0:4];
  logic [3:0] sqwRate;
  logic alarmFlag, alarmPend, wdFlag, wdIrq;
  logic [`RAW_PRESCALE_W-1:0] prescale;
  logic [4:0] wdCount;
  logic wdExpired;

  // address decode
  wire hitCtrl = regReq.addr == `RAW_ADDR_CTRL;
  wire hitWd = regReq.addr == `RAW_ADDR_WDOG;
  wire hitAlarm = regReq.addr >= `RAW_ADDR_ALARM_MONTH_AND_ENABLES && regReq.addr <= `RAW_ADDR_AL_SEC; // RULE1
  wire hitFlags = regReq.addr == `RAW_ADDR_FLAGS;
  wire hitSqw = regReq.addr == `RAW_ADDR_SQW;
  wire [2:0] alarmIdx = 3'(regReq.addr - `RAW_ADDR_ALARM_MONTH_AND_ENABLES);
  wire wdWrite = regReq.wr & hitWd;
  wire flagsRead = regReq.rd & hitFlags;

  wire [7:0] flagsValue = {wdFlag, alarmFlag, 1'b0, batteryLowFlag, 4'h0}; // RULE25
  wire [7:0] readMux = hitCtrl ? ctrlReg :
                       hitWd ? wdReg :
                       hitAlarm ? alarmReg[alarmIdx] :
                       hitFlags ? flagsValue :
                       hitSqw ? {sqwRate, 4'h0} :
                       `RAW_ZERO_BYTE;

  // enables and fields
  wire alarmPinEn = alarmReg[0][`RAW_AL_PIN_EN_BIT];
  wire backupAlarmEn = alarmReg[0][`RAW_BK_AL_EN_BIT];
  wire squareWaveEn = alarmReg[0][`RAW_SQW_EN_BIT];
  wire ftBit = ctrlReg[`RAW_CTRL_FT_BIT];
  wire outBit = ctrlReg[`RAW_CTRL_OUT_BIT];
  wire routeReset = wdReg[`RAW_WD_ROUTE_BIT];
  wire [4:0] wdMult = wdReg[`RAW_WD_MULT_MSB:`RAW_WD_MULT_LSB]; // RULE10
  wire [1:0] wdRes = wdReg[`RAW_WD_RES_MSB:`RAW_WD_RES_LSB]; // RULE10
  wire wdArmed = wdMult != 5'h0;

  // alarm compare
  wire [4:0] repeatCode = {alarmReg[1][`RAW_RPT5_BIT], alarmReg[1][`RAW_RPT_BIT], alarmReg[2][`RAW_RPT_BIT],
                           alarmReg[3][`RAW_RPT_BIT], alarmReg[4][`RAW_RPT_BIT]};
  wire raw_scope_t scope = scopeOf(repeatCode); // RULE2
  wire monthEq = fieldEq(alarmReg[0], timeNow.month, `RAW_MASK_MONTH);
  wire dateEq = fieldEq(alarmReg[1], timeNow.date, `RAW_MASK_DATE);
  wire hourEq = fieldEq(alarmReg[2], timeNow.hour, `RAW_MASK_HOUR);
  wire minEq = fieldEq(alarmReg[3], timeNow.minute, `RAW_MASK_MIN);
  wire secEq = fieldEq(alarmReg[4], timeNow.second, `RAW_MASK_SEC);
  wire alarmMatch = (scope == RAW_SCOPE_SECOND) ||
                    (secEq && (scope == RAW_SCOPE_MINUTE ||
                    (minEq && (scope == RAW_SCOPE_HOUR ||
                    (hourEq && (scope == RAW_SCOPE_DAY ||
                    (dateEq && (scope == RAW_SCOPE_MONTH || monthEq)))))))); // RULE2
  // evaluated only on the seconds update, so one match flags once
  wire alarmSet = secTick & alarmMatch; // RULE27
  wire pinAllowed = alarmPinEn & (~backup | backupAlarmEn); // RULE8

  // watchdog timing; phase of the free prescaler gives the one-step slack
  wire resTick = oscRise && ((prescale & resMask(wdRes)) == resMask(wdRes)); // RULE12
  wire wdRestart = kickEdge | wdWrite; // RULE16
  wire wdTimeout = resTick & wdArmed & ~wdExpired & ~wdRestart & (5'(wdCount + 5'h1) == wdMult); // RULE11
  wire wdResetFire = wdTimeout & routeReset; // RULE14
  wire powerClear = powerUp | wdResetFire;

  // register writes
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      ctrlReg <= `RAW_CTRL_RST; // RULE26
      wdReg <= `RAW_ZERO_BYTE; // RULE18
      alarmReg[0] <= `RAW_ZERO_BYTE; // RULE9
      alarmReg[1] <= `RAW_ZERO_BYTE;
      alarmReg[2] <= `RAW_AL_HOUR_RST; // RULE26
      alarmReg[3] <= `RAW_ZERO_BYTE;
      alarmReg[4] <= `RAW_ZERO_BYTE;
      sqwRate <= 4'h0;
    end else begin
      if (regReq.wr && hitCtrl) begin
        ctrlReg <= regReq.wdata;
      end
      if (regReq.wr && hitAlarm) begin
        alarmReg[alarmIdx] <= regReq.wdata;
      end
      if (regReq.wr && hitSqw) begin
        sqwRate <= regReq.wdata[`RAW_SQW_RATE_MSB:`RAW_SQW_RATE_LSB];
      end
      if (wdResetFire || powerUp) begin
        wdReg <= `RAW_ZERO_BYTE; // RULE15
      end else if (wdWrite) begin
        wdReg <= regReq.wdata;
      end
      if (powerClear) begin
        ctrlReg[`RAW_CTRL_FT_BIT] <= 1'b0; // RULE15
        alarmReg[0][`RAW_AL_PIN_EN_BIT] <= 1'b0; // RULE9
        alarmReg[0][`RAW_BK_AL_EN_BIT] <= 1'b0; // RULE9
        alarmReg[0][`RAW_SQW_EN_BIT] <= 1'b0; // RULE15
      end
      if (powerUp) begin
        alarmReg[2][`RAW_HT_BIT] <= 1'b1; // RULE26
      end
    end
  end

  // read data, one cycle after the strobe
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      regRdata <= `RAW_ZERO_BYTE;
    end else if (regReq.rd) begin
      regRdata <= readMux;
    end
  end

  // sticky flags; a set in the clearing cycle wins
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      alarmFlag <= 1'b0;
      alarmPend <= 1'b0;
      wdFlag <= 1'b0;
      wdIrq <= 1'b0;
    end else begin
      alarmFlag <= alarmSet | (alarmFlag & ~flagsRead); // RULE4
      alarmPend <= (alarmSet & pinAllowed) | (alarmPend & ~flagsRead); // RULE7
      wdFlag <= wdTimeout | (wdFlag & ~flagsRead); // RULE13
      wdIrq <= (wdTimeout & ~routeReset) | (wdIrq & ~(wdWrite && regReq.wdata == `RAW_ZERO_BYTE)); // RULE17
    end
  end

  // prescaler and watchdog count
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      prescale <= '0;
    end else if (oscRise) begin
      prescale <= prescale + 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst || wdRestart || !wdArmed) begin
      wdCount <= 5'h0; // RULE16
      wdExpired <= 1'b0;
    end else if (resTick && !wdExpired) begin
      wdCount <= 5'(wdCount + 5'h1);
      wdExpired <= wdTimeout;
    end
  end

  // shared open-drain interrupt pin
  wire ptrOnFlags = addrPtr == `RAW_ADDR_FLAGS;
  wire alarmDrive = alarmPend & pinAllowed & ~ptrOnFlags; // RULE5
  // watchdog routed to the pin keeps frequency test off
  wire ftOn = ftBit & ~alarmPinEn & (routeReset | wdReg == `RAW_ZERO_BYTE) & ~oscillatorHalt; // RULE19
  wire outMode = ~ftBit & ~alarmPinEn & (wdReg == `RAW_ZERO_BYTE);
  wire ftLow = ftOn & ~prescale[`RAW_FT_TAP];
  wire next_irqOe = wdIrq | alarmDrive | (supplySync & (ftLow | (outMode & ~outBit))); // RULE4

  // square wave and fixed outputs
  wire [3:0] rateTap = 4'(sqwRate - 4'h1);
  wire rateLevel = (sqwRate == `RAW_SQW_OSC_CODE) ? oscSync : prescale[rateTap]; // RULE20
  wire next_sqw = squareWaveEn & (sqwRate != `RAW_SQW_OFF_CODE) & rateLevel & supplySync; // RULE21
  wire next_fixed_32khz_output = oscSync & ~oscillatorHalt & supplySync; // RULE22

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      sharedIrqOut <= 1'b0;
      sharedIrqOe <= 1'b0;
      squareWavePin <= 1'b0;
      fixed32khzOutput <= 1'b0;
    end else begin
      sharedIrqOut <= 1'b0;
      sharedIrqOe <= next_irqOe;
      squareWavePin <= next_sqw;
      fixed32khzOutput <= next_fixed_32khz_output;
    end
  end

  // reset output sequencing
  raw_rst_state_t rstState, next_rstState;
  logic [31:0] recCount;
  wire [31:0] recLoad = recoveryLengthSelect ? 32'(RESET_RECOVERY_TIME_FAST_CYC) :
                        oscillatorHalt ? 32'(RESET_RECOVERY_TIME_HALT_CYC) : 32'(RESET_RECOVERY_TIME_NORM_CYC); // RULE24
  wire recLoadNow = (rstState == RAW_RST_FAIL && supplySync) ||
                    (rstState == RAW_RST_RUN && supplySync && wdResetFire);

  always_comb begin
    next_rstState = rstState;
    case (rstState)
      RAW_RST_RUN: begin
        if (!supplySync) begin
          next_rstState = RAW_RST_FAIL; // RULE23
        end else if (wdResetFire) begin
          next_rstState = RAW_RST_RECOVER; // RULE14
        end
      end
      RAW_RST_FAIL: begin
        if (supplySync) begin
          next_rstState = RAW_RST_RECOVER; // RULE23
        end
      end
      default: begin
        if (!supplySync) begin
          next_rstState = RAW_RST_FAIL;
        end else if (recCount == 32'h1) begin
          next_rstState = RAW_RST_RUN;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      rstState <= RAW_RST_FAIL;
      recCount <= 32'h0;
      resetOut <= 1'b0;
      resetOe <= 1'b1;
    end else begin
      rstState <= next_rstState;
      recCount <= recLoadNow ? recLoad : (recCount != 32'h0 ? recCount - 32'h1 : 32'h0);
      resetOut <= 1'b0;
      resetOe <= next_rstState != RAW_RST_RUN; // RULE23
    end
  end

endmodule

// ---- tb/raw_alarm_wdog_sva.sv ----
// port assertions for the alarm, watchdog and square-wave block
module raw_alarm_wdog_sva
  import raw_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // register port
  input raw_reg_req_t regReq,
  input wire logic [7:0] regRdata,
  // monitors
  input wire logic oscillatorHalt,
  input wire logic batteryLowFlag,
  input wire logic supplyOk,
  // pins
  input wire logic sharedIrqOut,
  input wire logic resetOut,
  input wire logic resetOe,
  input wire logic squareWavePin,
  input wire logic fixed32khzOutput
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);

  sequence flagsRead;
    regReq.rd && regReq.addr == 8'h0f;
  endsequence
  // synchroniser plus state register, so allow some edges of settling
  sequence backupSettled;
    !supplyOk [*6];
  endsequence

  chk_reset_holds_pin: assert property ($fell(sys_rst) |-> resetOe)
    else $error("reset pin released at reset exit");
  chk_flags_layout: assert property (flagsRead |=> regRdata[5] == 1'b0 && regRdata[3:0] == 4'h0
    && regRdata[4] == $past(batteryLowFlag)) else $error("flags spare bits wrong");
  chk_sqw_low_nibble: assert property (regReq.rd && regReq.addr == 8'h13 |=> regRdata[3:0] == 4'h0)
    else $error("rate register low nibble not zero");
  chk_reserved_reads_zero: assert property (regReq.rd && regReq.addr inside {[8'h10:8'h12]}
    |=> regRdata == 8'h00) else $error("reserved register not zero");
  chk_rdata_holds: assert property (!regReq.rd |=> $stable(regRdata))
    else $error("read data moved without a read");
  chk_open_drain_data: assert property (sharedIrqOut == 1'b0 && resetOut == 1'b0)
    else $error("open-drain data not low");
  chk_halt_stops_32k: assert property (oscillatorHalt [*3] |-> !fixed32khzOutput)
    else $error("fixed output runs while halted");
  chk_backup_quiet: assert property (backupSettled |-> !fixed32khzOutput && !squareWavePin)
    else $error("outputs run in back-up");
  chk_fail_pulls_reset: assert property (backupSettled |-> resetOe)
    else $error("reset pin not low on power fail");
endmodule

bind raw_alarm_wdog raw_alarm_wdog_sva sva_u (.core_clk(core_clk), .sys_rst(sys_rst), .regReq(regReq),
  .regRdata(regRdata), .oscillatorHalt(oscillatorHalt), .batteryLowFlag(batteryLowFlag), .supplyOk(supplyOk),
  .sharedIrqOut(sharedIrqOut), .resetOut(resetOut), .resetOe(resetOe), .squareWavePin(squareWavePin),
  .fixed32khzOutput(fixed32khzOutput));

// ---- tb/raw_host_model.sv ----
// host processor model driving the register port
module raw_host_model
  import raw_pkg::*;
(
  // clock
  input wire logic core_clk,
  // register port
  output raw_reg_req_t regReq,
  output logic [7:0] addrPtr,
  input wire logic [7:0] regRdata
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    regReq = '0;
    addrPtr = 8'h00;
  end
  // one byte per call; released lines show inverted values, not the last ones
  task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    @(negedge core_clk);
    regReq = '{addr: a, wr: w, rd: !w, wdata: d};
    addrPtr = a;
    @(negedge core_clk);
    regReq = '{addr: ~a, wr: 1'b0, rd: 1'b0, wdata: ~d};
    addrPtr = a + 8'h01;
    q = regRdata;
  endtask
endmodule

// ---- tb/raw_alarm_wdog_tb.sv ----
// self-checking bench for the alarm, watchdog and square-wave block
module raw_alarm_wdog_tb
  import raw_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic [7:0] a; logic [7:0] d; logic [7:0] e;} raw_row_t;
  raw_row_t rows [7] = '{'{8'h13, 8'hf5, 8'hf0}, '{8'h0d, 8'h59, 8'h59}, '{8'h09, 8'h0e, 8'h0e},
    '{8'h0f, 8'hff, 8'h10}, '{8'h11, 8'h5a, 8'h00}, '{8'h3f, 8'h77, 8'h00}, '{8'h0b, 8'hc5, 8'hc5}};
  logic [15:0] bk [6] = '{16'h0e80, 16'h0d80, 16'h0c80, 16'h0bc0, 16'h1310, 16'h0ae0};
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic secTick = 1'b0;
  logic oscillatorHalt = 1'b0;
  logic batteryLowFlag = 1'b1;
  logic oscPin = 1'b0;
  logic supplyOk = 1'b1;
  logic watchdogKickInput = 1'b0;
  raw_time_t timeNow = '{8'h05, 8'h12, 8'h08, 8'h30, 8'h00};
  raw_reg_req_t regReq;
  logic [7:0] addrPtr, regRdata, q;
  logic sharedIrqOut, sharedIrqOe, resetOut, resetOe, squareWavePin, fixed32khzOutput;
  int err_count = 0;
  int cmp_count = 0;
  int waited;

  raw_alarm_wdog #(.RESET_RECOVERY_TIME_NORM_CYC(20), .RESET_RECOVERY_TIME_HALT_CYC(30), .RESET_RECOVERY_TIME_FAST_CYC(5)) dut_u (.core_clk(core_clk),
    .sys_rst(sys_rst), .regReq(regReq), .addrPtr(addrPtr), .regRdata(regRdata), .secTick(secTick),
    .timeNow(timeNow), .oscillatorHalt(oscillatorHalt), .recoveryLengthSelect(1'b0),
    .batteryLowFlag(batteryLowFlag), .oscPin(oscPin), .supplyOk(supplyOk), .watchdogKickInput(watchdogKickInput),
    .sharedIrqOut(sharedIrqOut), .sharedIrqOe(sharedIrqOe), .resetOut(resetOut), .resetOe(resetOe),
    .squareWavePin(squareWavePin), .fixed32khzOutput(fixed32khzOutput));
  raw_host_model host_u (.core_clk(core_clk), .regReq(regReq), .addrPtr(addrPtr), .regRdata(regRdata));

  always #2 core_clk = ~core_clk;
  // fast oscillator stand-in keeps watchdog steps short
  always #8 oscPin = ~oscPin;

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string w);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t %s got %h exp %h", $time, w, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host_u.access(1'b1, a, d, q);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e, input string w);
    host_u.access(1'b0, a, 8'h00, q);
    chk(q, e, w);
  endtask
  task automatic waitChk(input logic rst, input logic want, input int n, input string w);
    for (waited = 0; waited < n && (rst ? resetOe : sharedIrqOe) !== want; waited++) begin
      @(negedge core_clk);
    end
    chk({7'h0, rst ? resetOe : sharedIrqOe}, {7'h0, want}, w);
  endtask
  task automatic tick();
    @(negedge core_clk);
    secTick = 1'b1;
    @(negedge core_clk);
    secTick = 1'b0;
  endtask
  task automatic levels(ref logic s, input string w);
    logic [1:0] seen;
    seen = 2'b00;
    repeat (64) begin
      @(negedge core_clk);
      seen[s] = 1'b1;
    end
    chk({6'h0, seen}, 8'h03, w);
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    // about 90k cycles, well above the longest watchdog wait
    #360000;
    err_count++;
    $display("BAD %0t run did not complete", $time);
    tally_and_finish();
  end

  initial begin
    repeat (2) @(negedge core_clk);
    sys_rst = 1'b0;
    waitChk(1'b1, 1'b0, 60, "recovery end");
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      rdc(rows[i].a, rows[i].e, "table row");
    end
    $display("test table done");
    sys_rst = 1'b1;
    repeat (2) @(negedge core_clk);
    sys_rst = 1'b0;
    rdc(8'h09, 8'h00, "wdog default");
    rdc(8'h0a, 8'h00, "enables default");
    rdc(8'h0c, 8'h40, "hold bit default");
    rdc(8'h08, 8'h80, "ctrl default");
    waitChk(1'b1, 1'b0, 60, "recovery end");
    $display("test reset done");
    wr(8'h0a, 8'h80);
    wr(8'h0b, 8'hc0);
    wr(8'h0c, 8'h80);
    wr(8'h0d, 8'h80);
    wr(8'h0e, 8'h80);
    tick();
    repeat (4) @(negedge core_clk);
    chk({7'h0, sharedIrqOe}, 8'h00, "pointer hold");
    rdc(8'h0a, 8'h80, "month reg");
    waitChk(1'b0, 1'b1, 4, "alarm pin");
    rdc(8'h0f, 8'h50, "alarm flag");
    waitChk(1'b0, 1'b0, 3, "pin release");
    rdc(8'h0f, 8'h10, "flag cleared");
    wr(8'h0d, 8'h00);
    tick();
    waitChk(1'b0, 1'b1, 4, "odd code");
    rdc(8'h0f, 8'h50, "odd code flag");
    wr(8'h0e, 8'h00);
    wr(8'h0c, 8'h00);
    wr(8'h0b, 8'h00);
    tick();
    repeat (4) @(negedge core_clk);
    rdc(8'h0f, 8'h10, "alarm off");
    $display("test alarm done");
    foreach (bk[i]) wr(bk[i][15:8], bk[i][7:0]);
    levels(squareWavePin, "square wave");
    levels(fixed32khzOutput, "fixed output");
    oscillatorHalt = 1'b1;
    repeat (4) @(negedge core_clk);
    chk({7'h0, fixed32khzOutput}, 8'h00, "halted");
    oscillatorHalt = 1'b0;
    supplyOk = 1'b0;
    repeat (8) @(negedge core_clk);
    chk({6'h0, resetOe, squareWavePin}, 8'h02, "back-up pins");
    tick();
    waitChk(1'b0, 1'b1, 4, "back-up alarm");
    supplyOk = 1'b1;
    waitChk(1'b1, 1'b0, 60, "power-up recovery");
    rdc(8'h0a, 8'h00, "enables cleared");
    rdc(8'h0c, 8'hc0, "hold bit set");
    rdc(8'h0f, 8'h50, "boot flag");
    $display("test back-up done");
    wr(8'h09, 8'h0c);
    for (int i = 0; i < 3; i++) begin
      repeat (6000) @(negedge core_clk);
      if (i == 1) wr(8'h09, 8'h0c);
      else watchdogKickInput = ~watchdogKickInput;
      chk({7'h0, sharedIrqOe}, 8'h00, "kicked");
    end
    waitChk(1'b0, 1'b1, 40000, "watchdog pin");
    chk({7'h0, waited > 16000 && waited < 33000}, 8'h01, "period");
    rdc(8'h0f, 8'h90, "watchdog flag");
    wr(8'h09, 8'h00);
    waitChk(1'b0, 1'b0, 4, "watchdog release");
    rdc(8'h0f, 8'h10, "watchdog flag cleared");
    wr(8'h08, 8'hc0);
    wr(8'h09, 8'h0c);
    q = 8'h00;
    repeat (300) begin
      @(negedge core_clk);
      q[0] = q[0] | sharedIrqOe;
    end
    chk(q, 8'h00, "test output denied");
    wr(8'h09, 8'h00);
    waitChk(1'b0, 1'b1, 300, "test output");
    wr(8'h08, 8'h80);
    wr(8'h0a, 8'he0);
    wr(8'h09, 8'h84);
    waitChk(1'b1, 1'b1, 17000, "watchdog reset");
    waitChk(1'b1, 1'b0, 60, "reset pulse end");
    rdc(8'h09, 8'h00, "wdog cleared");
    rdc(8'h0a, 8'h00, "enables cleared");
    $display("test watchdog done");
    tally_and_finish();
  end
endmodule
